//--- rtxs_core.sv
// transmit serializer of the radio baseband with event flags and interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "rtxs_consts.svh"

module rtxs_core (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       tx_bit_clk_i,
  output logic            tx_bit_o,
  output logic            tx_data_flag_o,
  output logic            tx_active_o,
  output logic            irq_o
);

  // bit clock synchroniser and edge detector
  logic bclk_meta;
  logic bclk_sync;
  logic bclk_prev;
  logic bit_edge;

  // software registers
  logic [1:0] ctrl;
  logic [3:0] mask;
  logic [7:0] bit_valid;
  logic [1:0] next_ctrl;
  logic [3:0] next_mask;
  logic [7:0] next_bit_valid;
  logic [7:0] next_rdata;

  // holding stage
  logic             hold_full;
  rtxs_pkg::rtxs_word_t hold_word;
  logic             next_hold_full;
  rtxs_pkg::rtxs_word_t next_hold_word;

  // buffer between holding stage and shifter
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  rtxs_pkg::rtxs_word_t fifo_out_word;
  logic             hold_moves;

  // shifter
  logic [7:0] sh_data;
  logic [7:0] sh_valid;
  logic       sent_any;
  logic [7:0] next_sh_data;
  logic [7:0] next_sh_valid;
  logic       next_sent_any;
  logic       next_tx_bit;
  logic       next_tx_data_flag;
  logic       next_tx_active;

  // flags and mode tracking
  rtxs_pkg::rtxs_flags_t flags;
  rtxs_pkg::rtxs_flags_t next_flags;
  logic                  tx_mode;
  logic                  tx_mode_prev;
  logic                  next_irq;
  logic                  next_tx_mode;

  // decoded host accesses and shifter events
  logic wr_ctrl;
  logic wr_mask;
  logic wr_valid;
  logic wr_byte;
  logic rd_flags;
  logic sh_empty;
  logic load;
  logic shift_evt;
  logic finish_evt;
  logic nothing_waits;
  logic underflow_evt;
  logic overflow_evt;
  logic done_evt;
  logic empty_evt;

  // the bit clock comes from outside, so it passes two flops before anything looks at it
  // the edge detector resets low like the idle pin, so leaving reset makes no false edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bclk_meta <= 1'b0;
      bclk_sync <= 1'b0;
      bclk_prev <= 1'b0;
    end else begin
      bclk_meta <= tx_bit_clk_i;
      bclk_sync <= bclk_meta;
      bclk_prev <= bclk_sync;
    end
  end

  assign bit_edge = bclk_sync && !bclk_prev;

  // host access decode; registers sit at their printed offsets
  assign wr_ctrl  = reg_wr_i && (reg_addr_i == `RTXS_ADDR_CTRL);
  assign wr_mask  = reg_wr_i && (reg_addr_i == `RTXS_ADDR_IRQ_MASK);
  assign wr_valid = reg_wr_i && (reg_addr_i == `RTXS_ADDR_BIT_VALID);
  assign wr_byte  = reg_wr_i && (reg_addr_i == `RTXS_ADDR_BYTE_HOLD);
  assign rd_flags = reg_rd_i && (reg_addr_i == `RTXS_ADDR_EVENT_FLAGS);

  // transmit mode needs tx enable with rx enable off, the radio runs one way at a time
  assign tx_mode = ctrl[1] && !ctrl[0];

  // the request follows the mode of the coming cycle, so it drops together with the enables
  assign next_tx_mode = next_ctrl[1] && !next_ctrl[0];

  // software register writes and the registered read port
  always_comb begin
    next_ctrl      = ctrl;
    next_mask      = mask;
    next_bit_valid = bit_valid;
    next_rdata     = reg_rdata_o;
    if (wr_ctrl) begin
      next_ctrl = {reg_wdata_i[`RTXS_CTRL_TX_EN_BIT], reg_wdata_i[`RTXS_CTRL_RX_EN_BIT]};
    end
    if (wr_mask) begin
      next_mask = reg_wdata_i[3:0];
    end
    if (wr_valid) begin
      next_bit_valid = reg_wdata_i;
    end
    // a write to the flag register has no case here, so it is dropped
    if (reg_rd_i) begin
      case (reg_addr_i)
        `RTXS_ADDR_CTRL:        next_rdata = {ctrl, 6'h00};
        `RTXS_ADDR_IRQ_MASK:    next_rdata = {4'h0, mask};
        `RTXS_ADDR_EVENT_FLAGS: begin
          // the flag register lags the mode by one cycle, so the read itself is gated too
          next_rdata = tx_mode ? {4'h0, flags} : `RTXS_READ_ZERO;
        end
        `RTXS_ADDR_BIT_VALID:   next_rdata = bit_valid;
        default:                next_rdata = `RTXS_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl        <= `RTXS_RST_CTRL;
      mask        <= `RTXS_RST_MASK;
      bit_valid   <= `RTXS_RST_VALID;
      reg_rdata_o <= `RTXS_READ_ZERO;
    end else begin
      ctrl        <= next_ctrl;
      mask        <= next_mask;
      bit_valid   <= next_bit_valid;
      reg_rdata_o <= next_rdata;
    end
  end

  // holding stage: drains into the buffer only in transmit mode
  assign fifo_in_valid = hold_full && tx_mode;
  assign hold_moves    = fifo_in_valid && fifo_in_ready;

  // a write over a full holding stage replaces the old byte; in transmit mode the loss is flagged as overflow
  always_comb begin
    next_hold_full = hold_full;
    next_hold_word = hold_word;
    if (hold_moves) begin
      next_hold_full = 1'b0;
    end
    if (wr_byte) begin
      next_hold_full       = 1'b1;
      next_hold_word.data  = reg_wdata_i;
      next_hold_word.valid = bit_valid; // mask is taken with the byte it belongs to
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_full      <= 1'b0;
      hold_word.data <= `RTXS_RST_BYTE;
      hold_word.valid <= `RTXS_RST_VALID;
    end else begin
      hold_full <= next_hold_full;
      hold_word <= next_hold_word;
    end
  end

  // buffer stalls the holding stage only while all four of its entries are full
  rtxs_fifo #(
    .WIDTH ($bits(rtxs_pkg::rtxs_word_t)),
    .DEPTH (`RTXS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (hold_word),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_word),
    .out_ready_i (fifo_out_ready)
  );

  // shifter events
  // a byte whose valid mask is zero loads and leaves nothing to send
  assign sh_empty       = (sh_valid == 8'h00);
  assign load           = tx_mode && sh_empty && fifo_out_valid;
  assign fifo_out_ready = load;
  assign shift_evt      = tx_mode && bit_edge && !sh_empty;
  assign finish_evt     = shift_evt && (sh_valid[7:1] == 7'h00);
  assign nothing_waits  = !fifo_out_valid && !hold_full;

  // one bit per bit clock edge, lowest bit first; invalid positions send preamble
  always_comb begin
    next_sh_data      = sh_data;
    next_sh_valid     = sh_valid;
    next_sent_any     = sent_any;
    next_tx_bit       = tx_bit_o;
    next_tx_data_flag = tx_data_flag_o;
    if (load) begin
      next_sh_data  = fifo_out_word.data;
      next_sh_valid = fifo_out_word.valid;
    end else if (shift_evt) begin
      next_tx_bit       = sh_valid[0] ? sh_data[0] : `RTXS_PREAMBLE_BIT;
      next_tx_data_flag = sh_valid[0];
      next_sh_data      = {1'b0, sh_data[7:1]};
      next_sh_valid     = {1'b0, sh_valid[7:1]};
      next_sent_any     = 1'b1;
    end
    // leaving transmit mode clears only sent_any, so underflow waits for a new bit; the shifter keeps its unsent bits
    if (!tx_mode) begin
      next_sent_any = 1'b0;
    end
    next_tx_active = !(next_sh_valid == 8'h00);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_data        <= 8'h00;
      sh_valid       <= 8'h00;
      sent_any       <= 1'b0;
      tx_bit_o       <= `RTXS_PREAMBLE_BIT;
      tx_data_flag_o <= 1'b0;
      tx_active_o    <= 1'b0;
    end else begin
      sh_data        <= next_sh_data;
      sh_valid       <= next_sh_valid;
      sent_any       <= next_sent_any;
      tx_bit_o       <= next_tx_bit;
      tx_data_flag_o <= next_tx_data_flag;
      tx_active_o    <= next_tx_active;
    end
  end

  // flag events; underflow repeats on each idle bit edge but the flag is sticky anyway
  assign underflow_evt = tx_mode && bit_edge && sh_empty && nothing_waits && sent_any;
  // a held byte that moves on in the very cycle of the write is not lost, so no overflow
  assign overflow_evt  = tx_mode && wr_byte && hold_full && !hold_moves;
  assign done_evt      = finish_evt && nothing_waits;
  assign empty_evt     = hold_moves || (tx_mode && !tx_mode_prev && !hold_full);

  // sticky flags: a set in the same cycle as its clear wins, so no event is lost
  always_comb begin
    next_flags = flags;
    next_flags.underflow = (flags.underflow && !rd_flags) || underflow_evt;
    next_flags.overflow  = (flags.overflow && !rd_flags) || overflow_evt;
    next_flags.done      = (flags.done && !rd_flags) || done_evt;
    next_flags.empty     = (flags.empty && !wr_byte) || empty_evt;
    if (!tx_mode) begin
      next_flags = `RTXS_RST_FLAGS;
    end
    // the request is gated by the mask and the coming mode; flags themselves never look at the mask
    next_irq = next_tx_mode && (|(next_flags & next_mask));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags        <= `RTXS_RST_FLAGS;
      tx_mode_prev <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      flags        <= next_flags;
      tx_mode_prev <= tx_mode;
      irq_o        <= next_irq;
    end
  end

endmodule : rtxs_core

`default_nettype wire

//--- rtxs_consts.svh
// register offsets, field positions, reset values and fixed levels of the transmit serializer
`ifndef RTXS_CONSTS_SVH
`define RTXS_CONSTS_SVH

`define RTXS_ADDR_CTRL        8'h03
`define RTXS_ADDR_IRQ_MASK    8'h0D
`define RTXS_ADDR_EVENT_FLAGS 8'h0E
`define RTXS_ADDR_BYTE_HOLD   8'h0F
`define RTXS_ADDR_BIT_VALID   8'h10

`define RTXS_CTRL_TX_EN_BIT   7
`define RTXS_CTRL_RX_EN_BIT   6

`define RTXS_FLAG_UNDERFLOW   3
`define RTXS_FLAG_OVERFLOW    2
`define RTXS_FLAG_DONE        1
`define RTXS_FLAG_EMPTY       0

`define RTXS_RST_CTRL         2'h0
`define RTXS_RST_MASK         4'h0
`define RTXS_RST_FLAGS        4'h0
`define RTXS_RST_VALID        8'h00
`define RTXS_RST_BYTE         8'h00
`define RTXS_READ_ZERO        8'h00

`define RTXS_PREAMBLE_BIT     1'b0
`define RTXS_FIFO_DEPTH       4

`endif

//--- rtxs_pkg.sv
// types shared by the transmit serializer files
package rtxs_pkg;

  // one byte with its per-bit valid mask, as it travels to the shifter
  typedef struct packed {
    logic [7:0] valid;
    logic [7:0] data;
  } rtxs_word_t;

  // event flags in register bit order 3..0
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic done;
    logic empty;
  } rtxs_flags_t;

endpackage : rtxs_pkg

//--- rtxs_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rtxs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointers wrap naturally; depth is expected to be a power of two
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage entries carry no reset; only occupied entries are ever read
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge clk_i) begin
      if (push && (wr_ptr == AW'(e))) begin
        mem[e] <= in_data_i;
      end
    end
  end

endmodule : rtxs_fifo

`default_nettype wire

//--- rtxs_core_checker.sv
// port assertions for the transmit serializer core
`timescale 1ns/1ps
`default_nettype none
`include "rtxs_consts.svh"
module rtxs_core_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       tx_bit_clk_i,
  input wire logic       tx_bit_o,
  input wire logic       tx_data_flag_o,
  input wire logic       tx_active_o,
  input wire logic       irq_o
);
  logic       mode, next_mode;
  logic [3:0] mask, next_mask;
  logic [3:0] quiet, next_quiet;
  logic [3:0] off, next_off;
  logic       clk_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // shadow mode and mask; count cycles since a bit clock rise and while idle
  always_comb begin
    next_mode = mode;
    next_mask = mask;
    if (reg_wr_i && reg_addr_i == `RTXS_ADDR_CTRL) next_mode = reg_wdata_i[7] & ~reg_wdata_i[6];
    if (reg_wr_i && reg_addr_i == `RTXS_ADDR_IRQ_MASK) next_mask = reg_wdata_i[3:0];
    next_quiet = (tx_bit_clk_i && !clk_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
    next_off = mode ? 4'h0 : off + {3'h0, off != 4'hf};
  end

  // counters saturate so long idle spans never wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= 1'b0;
      mask <= 4'h0;
      quiet <= 4'h0;
      off <= 4'h0;
      clk_q <= 1'b0;
    end else begin
      mode <= next_mode;
      mask <= next_mask;
      quiet <= next_quiet;
      off <= next_off;
      clk_q <= tx_bit_clk_i;
    end
  end

  sequence flag_read;
    reg_rd_i && reg_addr_i == `RTXS_ADDR_EVENT_FLAGS;
  endsequence

  a_reserved_read_zero: assert property (flag_read |=> reg_rdata_o[7:4] == 4'h0)
    else $error("reserved flag bits not zero");
  a_irq_matches_flags: assert property (flag_read |=>
    $past(irq_o) == |(reg_rdata_o[3:0] & $past(mask))) else $error("irq disagrees with flags");
  a_mask_gates_irq: assert property (irq_o |-> mask != 4'h0)
    else $error("irq with all enables off");
  a_idle_no_irq: assert property (off > 4'h3 |-> !irq_o)
    else $error("irq outside transmit mode");
  a_idle_read_zero: assert property (flag_read and !mode |=> reg_rdata_o == 8'h00)
    else $error("flags nonzero outside transmit mode");
  a_idle_bit_still: assert property (off > 4'h3 |-> $stable(tx_bit_o))
    else $error("bit moved outside transmit mode");
  a_preamble_low: assert property (!tx_data_flag_o |-> !tx_bit_o)
    else $error("preamble bit not low");
  a_bit_holds: assert property (quiet > 4'h6 |->
    $stable(tx_bit_o) && $stable(tx_data_flag_o)) else $error("bit changed without bit clock");
  a_idle_shift_none: assert property (!tx_active_o |=>
    $stable(tx_bit_o) && $stable(tx_data_flag_o)) else $error("bit moved with empty shifter");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule : rtxs_core_checker

bind rtxs_core rtxs_core_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .tx_bit_clk_i(tx_bit_clk_i), .tx_bit_o(tx_bit_o),
  .tx_data_flag_o(tx_data_flag_o), .tx_active_o(tx_active_o), .irq_o(irq_o));
`default_nettype wire

//--- rtxs_link_model.sv
// far end of the link: bit clock within frames, capture of the sent bits
`timescale 1ns/1ps
`default_nettype none
module rtxs_link_model (
  input  wire logic       run_i,
  input  wire logic       bit_i,
  input  wire logic       kind_i,
  output logic            bit_clk_o,
  output logic      [7:0] bits_o,
  output logic      [7:0] kinds_o
);
  logic [3:0] cnt = 4'h0;

  // clock stands low between frames, 200 ns period within them
  initial begin
    bit_clk_o = 1'b0;
    forever begin
      #100;
      bit_clk_o = run_i ? ~bit_clk_o : 1'b0;
    end
  end

  // each rise samples the bit launched by the rise before, far from its update
  always @(posedge bit_clk_o or negedge run_i) begin
    if (!run_i) begin
      cnt <= 4'h0;
    end else begin
      if (cnt != 4'h0 && cnt < 4'h9) begin
        bits_o[cnt - 4'h1] <= bit_i;
        kinds_o[cnt - 4'h1] <= kind_i;
      end
      if (cnt < 4'hf) cnt <= cnt + 4'h1;
    end
  end
endmodule : rtxs_link_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the transmit serializer core
`timescale 1ns/1ps
`default_nettype none
`include "rtxs_consts.svh"
module testbench;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic       tx_bit_clk_i;
  logic       tx_bit_o;
  logic       tx_data_flag_o;
  logic       tx_active_o;
  logic       irq_o;
  logic       run = 1'b0;
  logic [7:0] cap_bits;
  logic [7:0] cap_kinds;
  int         err_count = 0;
  int         total_checks = 0;
  // rows: valid mask, data byte, bits sent, expected bits, expected bit kinds
  logic [7:0] rows [4][5] = '{
    '{8'hff, 8'ha5, 8'h08, 8'ha5, 8'hff},
    '{8'h0f, 8'h3c, 8'h04, 8'h0c, 8'h0f},
    '{8'h81, 8'h81, 8'h08, 8'h81, 8'h81},
    '{8'h55, 8'hff, 8'h07, 8'h55, 8'h55}};

  rtxs_core DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .tx_bit_clk_i(tx_bit_clk_i), .tx_bit_o(tx_bit_o), .tx_data_flag_o(tx_data_flag_o),
    .tx_active_o(tx_active_o), .irq_o(irq_o));
  rtxs_link_model link (.run_i(run), .bit_i(tx_bit_o), .kind_i(tx_data_flag_o),
    .bit_clk_o(tx_bit_clk_i), .bits_o(cap_bits), .kinds_o(cap_kinds));

  // 40 MHz system clock
  always #12.5 clk_i = ~clk_i;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // spaced writes so the holding stage settles between them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(name, exp, reg_rdata_o);
  endtask : rdchk

  // one frame of n bit periods, then the link clock stands still
  task automatic run_bits(input int n);
    run = 1'b1;
    repeat (n * 8) @(negedge clk_i);
    run = 1'b0;
    repeat (16) @(negedge clk_i);
  endtask : run_bits

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // main sequence: reset and register checks, then table rows, then the awkward cases
  initial begin : main
    logic [7:0] lo;
    int         n;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    chk("irq", 8'h00, {7'h00, irq_o});
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h00, "reset flags");
    wr(`RTXS_ADDR_CTRL, 8'h80);
    wr(`RTXS_ADDR_EVENT_FLAGS, 8'hff);
    run_bits(3);
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h01, "flags");
    rdchk(`RTXS_ADDR_BYTE_HOLD, 8'h00, "hold read");
    rdchk(8'h20, 8'h00, "unmapped read");
    foreach (rows[r]) begin
      n = int'(rows[r][2]);
      lo = 8'hff >> (8 - n);
      wr(`RTXS_ADDR_BIT_VALID, rows[r][0]);
      wr(`RTXS_ADDR_BYTE_HOLD, rows[r][1]);
      chk("tx active", 8'h01, {7'h00, tx_active_o});
      run_bits(n + 3);
      chk("bits", rows[r][3], cap_bits & lo);
      chk("bit kinds", rows[r][4], cap_kinds & lo);
      chk("tx active", 8'h00, {7'h00, tx_active_o});
      rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h0b, "flags");
      rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h01, "flags");
    end
    // shifter, four buffer words and holding stage fill; the seventh write overflows
    wr(`RTXS_ADDR_BIT_VALID, 8'hff);
    wr(`RTXS_ADDR_IRQ_MASK, 8'h04);
    for (int i = 0; i < 7; i++) wr(`RTXS_ADDR_BYTE_HOLD, 8'(8'h10 + i));
    chk("irq", 8'h01, {7'h00, irq_o});
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h04, "flags");
    chk("irq", 8'h00, {7'h00, irq_o});
    wr(`RTXS_ADDR_IRQ_MASK, 8'h0f);
    run_bits(51);
    chk("bits", 8'h10, cap_bits);
    chk("tx active", 8'h00, {7'h00, tx_active_o});
    chk("irq", 8'h01, {7'h00, irq_o});
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h0b, "flags");
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h01, "flags");
    wr(`RTXS_ADDR_IRQ_MASK, 8'h0e);
    chk("irq", 8'h00, {7'h00, irq_o});
    wr(`RTXS_ADDR_CTRL, 8'hc0);
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h00, "flags");
    rdchk(`RTXS_ADDR_CTRL, 8'hc0, "ctrl");
    wr(`RTXS_ADDR_CTRL, 8'h40);
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h00, "flags");
    // reset in mid-run: a byte sits in the shifter, then everything must return to idle
    wr(`RTXS_ADDR_CTRL, 8'h80);
    wr(`RTXS_ADDR_BYTE_HOLD, 8'h5a);
    chk("tx active", 8'h01, {7'h00, tx_active_o});
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("reset tx active", 8'h00, {7'h00, tx_active_o});
    chk("reset bit", 8'h00, {6'h00, tx_data_flag_o, tx_bit_o});
    chk("reset irq", 8'h00, {7'h00, irq_o});
    rst_i = 1'b0;
    rdchk(`RTXS_ADDR_CTRL, 8'h00, "reset ctrl");
    rdchk(`RTXS_ADDR_EVENT_FLAGS, 8'h00, "reset flags");
    chk("reset tx active", 8'h00, {7'h00, tx_active_o});
    finish_test();
  end

  // watchdog: the run needs about 25 us
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
